// >>> design/rss_pkg.sv
package rss_pkg;

   // Instruction encodings.
   localparam logic [15:0] SLEEP_OPCODE = 16'h0003;
   localparam logic [5:0]  ROTATE_OPC   = 6'h10;
   localparam logic [6:0]  FILL_OPC     = 7'h34;
   localparam int          ROTATE_TOP   = 10;
   localparam int          FILL_TOP     = 9;
   localparam int          DEST_BIT     = 9;
   localparam int          ACCESS_BIT   = 8;

   // Operand values and address limits.
   localparam logic [7:0]  ONES_VALUE   = 8'hff;
   localparam logic [7:0]  ZERO_VALUE   = 8'h00;
   localparam logic [7:0]  INDEX_LIMIT  = 8'h5f;
   localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
   localparam logic [3:0]  LOW_PAGE     = 4'h0;
   localparam logic [3:0]  SFR_PAGE     = 4'hf;

   // Register indices on the software port.
   localparam logic [3:0]  CTRL_IDX     = 4'h0;
   localparam logic [3:0]  STATUS_IDX   = 4'h1;
   localparam logic [3:0]  WREG_IDX     = 4'h2;
   localparam logic [3:0]  BANK_IDX     = 4'h3;
   localparam logic [3:0]  BASE_IDX     = 4'h4;

   // Field positions.
   localparam int          EXT_BIT      = 0;
   localparam int          ST_NEG       = 0;
   localparam int          ST_ZERO      = 1;
   localparam int          ST_TIMEOUT   = 2;
   localparam int          ST_PWRDOWN   = 3;
   localparam int          ST_SLEEP     = 4;

   // Reset values.
   localparam logic [7:0]  WREG_RESET   = 8'h00;
   localparam logic [3:0]  BANK_RESET   = 4'h0;
   localparam logic [11:0] BASE_RESET   = 12'h000;

   typedef logic [3:0]  reg_addr_t;
   typedef logic [11:0] data_addr_t;
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
   typedef enum logic [1:0] {OP_NONE, OP_ROT, OP_FILL, OP_SLEEP} op_t;

endpackage : rss_pkg

// >>> design/rotate_set_sleep.sv
// Notes on behaviour
// - Opcode 0100 00da ffffffff rotates operand right; bit 0 wraps into bit 7.
// - Destination bit 0 sends the result to W; 1 writes back to the register.
// - Access bit 0 uses the access bank; 1 uses the bank select register.
// - Extended set, access bit 0, address up to 5Fh: indexed literal offset addressing.
// - Rotate updates only negative and zero flags from the result.
// - Fill instruction writes FFh, keeps all flags, banks like the rotate.
// - Sleep clears the watchdog count and its postscaler.
// - Sleep sets the time-out flag and clears the power-down flag.
// - After sleep the core halts with its oscillator stopped.
// - Sleep is the fixed opcode 0000 0000 0000 0011.
// - A watchdog wake-up clears the time-out flag.
`timescale 1ns/100ps
module rotate_set_sleep
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // Software register port.
   input  wire rss_pkg::reg_addr_t reg_addr,
   input  wire logic [15:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [15:0]            reg_rdata,
   // Instruction fetch side.
   input  wire logic [15:0]       instr_word,
   input  wire logic              instr_valid,
   output logic                   instr_taken,
   // Data memory side; read data arrive one cycle after mem_rd.
   output rss_pkg::data_addr_t    mem_addr,
   output logic                   mem_rd,
   output logic                   mem_wr,
   output logic [7:0]             mem_wdata,
   input  wire logic [7:0]        mem_rdata,
   // Watchdog, wake and power control.
   input  wire logic              wdt_wake,
   input  wire logic              wake_event,
   output logic                   watchdog_counter_clear,
   output logic                   sleep_active,
   output logic                   osc_stop,
   output logic [7:0]             wreg,
   output logic                   timeout_flag,
   output logic                   powerdown_flag
);
   import rss_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // All state of the block in one record.
   typedef struct packed {
      phase_t     phase;
      op_t        op;
      logic [15:0] instr;
      logic [7:0] result;
      logic       ext_enable;
      logic [7:0] wreg;
      logic [3:0] bank_select_register;
      logic [11:0] index_base;
      logic       neg_flag;
      logic       zero_flag;
      logic       timeout_flag;
      logic       powerdown_flag;
      logic       sleeping;
      logic       watchdog_counter_clear;
      logic       taken;
      logic [11:0] mem_addr;
      logic       mem_rd;
      logic       mem_wr;
      logic [7:0] mem_wdata;
      logic [15:0] rdata;
   } state_t;

   state_t q;
   state_t d;
   logic [7:0] fa;

   assign fa = q.instr[7:0];

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic: software port first, so the core's own updates win a clash.
   always_comb
   begin
      d = q;
      d.mem_rd = 1'b0;
      d.mem_wr = 1'b0;
      d.watchdog_counter_clear = 1'b0;
      d.taken = 1'b0;
      d.rdata = 16'h0000;
      if (reg_rd)
      begin
         case (reg_addr)
            CTRL_IDX:   d.rdata[EXT_BIT] = q.ext_enable;
            STATUS_IDX:
            begin
               d.rdata[ST_NEG] = q.neg_flag;
               d.rdata[ST_ZERO] = q.zero_flag;
               d.rdata[ST_TIMEOUT] = q.timeout_flag;
               d.rdata[ST_PWRDOWN] = q.powerdown_flag;
               d.rdata[ST_SLEEP] = q.sleeping;
            end
            WREG_IDX:   d.rdata[7:0] = q.wreg;
            BANK_IDX:   d.rdata[3:0] = q.bank_select_register;
            BASE_IDX:   d.rdata[11:0] = q.index_base;
            default:    d.rdata = 16'h0000;
         endcase
      end
      if (reg_wr)
      begin
         case (reg_addr)
            CTRL_IDX:   d.ext_enable = reg_wdata[EXT_BIT];
            WREG_IDX:   d.wreg = reg_wdata[7:0];
            BANK_IDX:   d.bank_select_register = reg_wdata[3:0];
            BASE_IDX:   d.index_base = reg_wdata[11:0];
            default:    d.ext_enable = q.ext_enable;
         endcase
      end
      // A halted core only watches for wake-up; phases stay frozen at Q1.
      if (q.sleeping)
      begin
         if (wdt_wake)
         begin
            d.sleeping = 1'b0;
            d.timeout_flag = 1'b0;
         end
         else if (wake_event)
         begin
            d.sleeping = 1'b0;
         end
      end
      else
      begin
         case (q.phase)
            PH_Q1:
            begin
               // Decode; an absent word makes the cycle a no-op.
               d.op = OP_NONE;
               d.instr = instr_word;
               if (instr_valid)
               begin
                  d.taken = 1'b1;
                  if (instr_word[15:ROTATE_TOP] == ROTATE_OPC)
                     d.op = OP_ROT;
                  else if (instr_word[15:FILL_TOP] == FILL_OPC)
                     d.op = OP_FILL;
                  else if (instr_word == SLEEP_OPCODE)
                     d.op = OP_SLEEP;
               end
               d.phase = PH_Q2;
            end
            PH_Q2:
            begin
               // Operand read; sleep has nothing to fetch.
               if (q.op == OP_ROT || q.op == OP_FILL)
               begin
                  d.mem_rd = 1'b1;
                  if (!q.instr[ACCESS_BIT] && q.ext_enable && fa <= INDEX_LIMIT)
                     d.mem_addr = q.index_base + {4'h0, fa};
                  else if (!q.instr[ACCESS_BIT])
                     d.mem_addr = {(fa < ACCESS_SPLIT) ? LOW_PAGE : SFR_PAGE, fa};
                  else
                     d.mem_addr = {q.bank_select_register, fa};
               end
               d.phase = PH_Q3;
            end
            PH_Q3:
            begin
               // The memory answers during this cycle's successor.
               d.phase = PH_Q4;
            end
            PH_Q4:
            begin
               case (q.op)
                  OP_ROT:
                  begin
                     d.result = {mem_rdata[0], mem_rdata[7:1]};
                     d.neg_flag = mem_rdata[0];
                     d.zero_flag = (mem_rdata == ZERO_VALUE);
                     if (q.instr[DEST_BIT])
                     begin
                        d.mem_wr = 1'b1;
                        d.mem_wdata = {mem_rdata[0], mem_rdata[7:1]};
                     end
                     else
                     begin
                        d.wreg = {mem_rdata[0], mem_rdata[7:1]};
                     end
                  end
                  OP_FILL:
                  begin
                     d.result = ONES_VALUE;
                     d.mem_wr = 1'b1;
                     d.mem_wdata = ONES_VALUE;
                  end
                  OP_SLEEP:
                  begin
                     d.watchdog_counter_clear = 1'b1;
                     d.timeout_flag = 1'b1;
                     d.powerdown_flag = 1'b0;
                     d.sleeping = 1'b1;
                  end
                  default:
                  begin
                     d.result = q.result;
                  end
               endcase
               d.phase = PH_Q1;
            end
            default:
            begin
               d.phase = PH_Q1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; the time-out and power-down flags come up set after a power-on.
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q <= '0;
         q.phase <= PH_Q1;
         q.op <= OP_NONE;
         q.wreg <= WREG_RESET;
         q.bank_select_register <= BANK_RESET;
         q.index_base <= BASE_RESET;
         q.timeout_flag <= 1'b1;
         q.powerdown_flag <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // Every output is a field of the state register.
   assign reg_rdata = q.rdata;
   assign instr_taken = q.taken;
   assign mem_addr = q.mem_addr;
   assign mem_rd = q.mem_rd;
   assign mem_wr = q.mem_wr;
   assign mem_wdata = q.mem_wdata;
   assign watchdog_counter_clear = q.watchdog_counter_clear;
   assign sleep_active = q.sleeping;
   assign osc_stop = q.sleeping; // The clock source is gated by the core outside.
   assign wreg = q.wreg;
   assign timeout_flag = q.timeout_flag;
   assign powerdown_flag = q.powerdown_flag;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_rotate_data: assert property (@(posedge sys_clk) disable iff (!resetn)
      mem_wr && q.op == OP_ROT |-> mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
      else $error("Rotate wrote a wrong value.");
   a_wreg_dest: assert property (@(posedge sys_clk) disable iff (!resetn)
      q.phase == PH_Q4 && q.op == OP_ROT && !q.instr[DEST_BIT] && !q.sleeping
      |=> !mem_wr && wreg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
      else $error("Rotate to W went astray.");
   a_bank_select: assert property (@(posedge sys_clk) disable iff (!resetn)
      mem_rd && q.instr[ACCESS_BIT] |-> mem_addr == {$past(q.bank_select_register), fa})
      else $error("Banked address wrong.");
   a_indexed_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
      mem_rd && !q.instr[ACCESS_BIT] && $past(q.ext_enable) && fa <= INDEX_LIMIT
      |-> mem_addr == $past(q.index_base) + {4'h0, fa})
      else $error("Indexed address wrong.");
   a_zero_flag: assert property (@(posedge sys_clk) disable iff (!resetn)
      q.phase == PH_Q4 && q.op == OP_ROT && !q.sleeping
      |=> q.zero_flag == ($past(mem_rdata) == ZERO_VALUE) && q.neg_flag == $past(mem_rdata[0])
          && q.neg_flag == q.result[7])
      else $error("Rotate flags wrong.");
   a_fill_ones: assert property (@(posedge sys_clk) disable iff (!resetn)
      mem_wr && q.op == OP_FILL |-> mem_wdata == ONES_VALUE && $stable(q.zero_flag) && $stable(q.neg_flag))
      else $error("Fill wrote a wrong value or touched flags.");
   a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
      watchdog_counter_clear |-> sleep_active && timeout_flag && !powerdown_flag && $past(q.op) == OP_SLEEP)
      else $error("Sleep entry incomplete.");
   a_sleep_decode: assert property (@(posedge sys_clk) disable iff (!resetn)
      q.phase == PH_Q1 && !q.sleeping && instr_valid && instr_word == SLEEP_OPCODE
      |-> ##3 q.op == OP_SLEEP ##1 watchdog_counter_clear && osc_stop)
      else $error("Sleep opcode not honoured.");
   a_watchdog_wake: assert property (@(posedge sys_clk) disable iff (!resetn)
      sleep_active && wdt_wake |=> !sleep_active && !timeout_flag)
      else $error("Watchdog wake mishandled.");
   a_phase_order: assert property (@(posedge sys_clk) disable iff (!resetn)
      q.phase == PH_Q1 && !q.sleeping |=> q.phase == PH_Q2 ##1 q.phase == PH_Q3 ##1 q.phase == PH_Q4)
      else $error("Phase order broken.");

endmodule : rotate_set_sleep

// >>> bench/test_rotate_set_sleep.sv
`timescale 1ns/100ps
module test_rotate_set_sleep;
   import rss_pkg::*;
   logic        sys_clk, resetn, reg_wr, reg_rd, instr_valid, instr_taken, mem_rd, mem_wr;
   logic        wdt_wake, wake_event, watchdog_counter_clear, sleep_active, osc_stop;
   logic        timeout_flag, powerdown_flag, s_rd, s_wr, s_clr, s_slp, s_osc, s_to, s_pd;
   logic        e_neg, e_zero, e_to, e_pd;
   reg_addr_t   reg_addr;
   data_addr_t  mem_addr, s_addr;
   logic [15:0] reg_wdata, reg_rdata, instr_word, rv;
   logic [7:0]  mem_wdata, mem_rdata, wreg, s_wdata, s_wreg;
   int          errors, comparisons, cycles;

   rotate_set_sleep rotate_set_sleep_i (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_word(instr_word), .instr_valid(instr_valid), .instr_taken(instr_taken),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .wdt_wake(wdt_wake), .wake_event(wake_event),
      .watchdog_counter_clear(watchdog_counter_clear), .sleep_active(sleep_active),
      .osc_stop(osc_stop), .wreg(wreg), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 125 MHz.
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // A stuck handshake must still end in a verdict, so the run is capped.
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         errors++;
         print_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task print_verdict();
      if (errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   // The strobe is lowered one edge before the task returns, so back-to-back calls never collide.
   task automatic reg_write(input reg_addr_t a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
      @(posedge sys_clk);
   endtask : reg_write

   task automatic reg_read(input reg_addr_t a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(posedge sys_clk);
      d = reg_rdata;
   endtask : reg_read

   task automatic status_is();
      reg_read(STATUS_IDX, rv);
      check("status", rv, {11'h000, 1'b0, e_pd, e_to, e_zero, e_neg});
   endtask : status_is

   // Runs one instruction and snapshots the memory side at the second and fourth cycle after acceptance.
   task automatic exec(input logic [15:0] word, input logic [7:0] rdv);
      int n;
      n = 0;
      instr_word  <= word;
      instr_valid <= 1'b1;
      @(posedge sys_clk);
      while (instr_taken !== 1'b1 && n < 12)
      begin
         @(posedge sys_clk);
         n++;
      end
      check("instr_taken", instr_taken, 1'b1);
      instr_valid <= 1'b0;
      @(posedge sys_clk);
      s_rd   = mem_rd;
      s_addr = mem_addr;
      mem_rdata <= rdv;
      @(posedge sys_clk);
      mem_rdata <= ~rdv;
      @(posedge sys_clk);
      {s_wr, s_wdata, s_wreg, s_clr, s_slp} = {mem_wr, mem_wdata, wreg, watchdog_counter_clear, sleep_active};
      {s_osc, s_to, s_pd} = {osc_stop, timeout_flag, powerdown_flag};
   endtask : exec

   task automatic rotate(input logic d, input logic a, input logic [7:0] f, input logic [7:0] v,
                         input data_addr_t addr);
      logic [7:0] r;
      r = {v[0], v[7:1]};
      exec({ROTATE_OPC, d, a, f}, v);
      check("rot_rd", s_rd, 1'b1);
      check("rot_addr", s_addr, addr);
      check("rot_wr", s_wr, d);
      if (d)
         check("rot_data", s_wdata, r);
      else
      begin
         // The W result must also be visible to software, not only on the wreg pins.
         check("rot_wreg", s_wreg, r);
         reg_read(WREG_IDX, rv);
         check("rot_wreg_port", rv, {8'h00, r});
      end
      e_neg  = r[7];
      e_zero = (r == 8'h00);
      status_is();
   endtask : rotate

   task automatic fill(input logic a, input logic [7:0] f, input data_addr_t addr);
      exec({FILL_OPC, a, f}, 8'h5a);
      check("fill_addr", s_addr, addr);
      check("fill_data", {s_wr, s_wdata}, 9'h1ff);
      status_is();
   endtask : fill

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      check("reset_flags", {timeout_flag, powerdown_flag, sleep_active}, 3'b110);
      status_is();
      reg_read(4'hf, rv);
      check("unmapped", rv, 16'h0000);
   endtask : test_reset

   // Covers both destinations, both bank modes and the indexed boundary at 5Fh/60h.
   task automatic test_addressing();
      rotate(1'b1, 1'b0, 8'h20, 8'hd7, 12'h020);
      reg_write(BANK_IDX, 16'h0005);
      rotate(1'b0, 1'b1, 8'h90, 8'h01, 12'h590);
      rotate(1'b0, 1'b0, 8'h90, 8'h00, 12'hf90);
      fill(1'b1, 8'ha0, 12'h5a0);
      fill(1'b0, 8'h10, 12'h010);
      reg_write(CTRL_IDX, 16'h0001);
      reg_write(BASE_IDX, 16'h0123);
      rotate(1'b1, 1'b0, 8'h5f, 8'h80, 12'h182);
      rotate(1'b1, 1'b0, 8'h60, 8'h02, 12'h060);
      fill(1'b0, 8'h00, 12'h123);
      fill(1'b1, 8'h00, 12'h500);
      reg_write(CTRL_IDX, 16'h0000);
      exec(16'h0002, 8'h00);
      check("near_sleep", {s_rd, s_wr, s_clr, s_slp}, 4'h0);
   endtask : test_addressing

   task automatic wake(input logic by_wdt);
      wdt_wake   <= by_wdt;
      wake_event <= ~by_wdt;
      @(posedge sys_clk);
      wdt_wake   <= 1'b0;
      wake_event <= 1'b0;
      @(posedge sys_clk);
   endtask : wake

   task automatic test_sleep();
      logic seen;
      exec(16'h0003, 8'h00);
      check("wdt_clear", s_clr, 1'b1);
      check("to_pd", {s_to, s_pd}, 2'b10);
      check("halted", {s_slp, s_osc}, 2'b11);
      check("sleep_rd", s_rd, 1'b0);
      seen = 1'b0;
      instr_valid <= 1'b1;
      repeat (8)
      begin
         @(posedge sys_clk);
         seen = seen | instr_taken;
      end
      instr_valid <= 1'b0;
      check("taken_asleep", seen, 1'b0);
      wake(1'b1);
      check("wdt_wake", {sleep_active, timeout_flag}, 2'b00);
      exec(16'h0003, 8'h00);
      check("to_set", {s_to, s_pd}, 2'b10);
      wake(1'b0);
      check("other_wake", {sleep_active, osc_stop, timeout_flag}, 3'b001);
      e_pd = 1'b0;
      rotate(1'b1, 1'b1, 8'h01, 8'h03, 12'h501);
   endtask : test_sleep

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: every input gets a value at time zero, then reset is held for six cycles.
   initial
   begin
      {resetn, reg_wr, reg_rd, instr_valid, wdt_wake, wake_event} = 6'h00;
      {reg_addr, reg_wdata, instr_word, mem_rdata} = 44'h0;
      {errors, comparisons, cycles} = {32'd0, 32'd0, 32'd0};
      {e_neg, e_zero, e_to, e_pd} = 4'b0011;
      repeat (6) @(posedge sys_clk);
      resetn <= 1'b1;
      test_reset();
      test_addressing();
      test_sleep();
      print_verdict();
   end
endmodule : test_rotate_set_sleep
